//--- universal_serial_module_spi_pkg.sv
/*
  Shared constants and types of the byte-wide SPI function of the serial
  module: register offsets, reset values, mode codes and register layouts.
  Assumes a 32-bit APB register bus and a 100 MHz system clock.
*/
`default_nettype none
package universal_serial_module_spi_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_MODE = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_FMT = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_DATA = 12'h008;
  localparam logic [7:0] MODE_RST = 8'hE0;
  localparam logic [7:0] FMT_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam int unsigned HALF_W = 6;
  localparam logic [HALF_W-1:0] DIV4_HALF = 6'h02;
  localparam logic [HALF_W-1:0] DIV16_HALF = 6'h08;
  localparam logic [HALF_W-1:0] DIV64_HALF = 6'h20;
  localparam logic [3:0] BIT_COUNT = 4'h8;
  localparam logic [4:0] EDGE_COUNT = 5'h10;

  typedef enum logic [2:0] {
    MD_DIV4 = 3'h0,
    MD_DIV16 = 3'h1,
    MD_DIV64 = 3'h2,
    MD_SUB = 3'h3,
    MD_TIMER = 3'h4,
    MD_SLAVE = 3'h5,
    MD_I2C = 3'h6,
    MD_UNUSED = 3'h7
  } mode_t;

  typedef struct packed {
    mode_t mode_field;
    logic uart_select_bit;
    logic [1:0] debounce_time_bits;
    logic module_enable_bit;
    logic incomplete_flag;
  } mode_ctl_t;

  typedef struct packed {
    logic [1:0] spare;
    logic clock_polarity_bit;
    logic capture_edge_bit;
    logic bit_order_bit;
    logic select_pin_enable;
    logic write_collision_flag;
    logic transfer_complete_flag;
  } fmt_ctl_t;

  typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} state_t;

  // SPI function selected: UART bit clear and an SPI mode code
  function automatic logic is_spi(input mode_ctl_t m);
    return !m.uart_select_bit && (m.mode_field <= MD_SLAVE);
  endfunction

  // Bit that leaves the shifter first for the chosen order
  function automatic logic first_bit(input logic [7:0] d,
                                     input logic msb_first);
    return msb_first ? d[7] : d[0];
  endfunction
endpackage
`default_nettype wire

//--- spi_sync2.sv
/*
  Two-flop synchroniser for a bundle of asynchronous pin levels.
  Assumes each bit is an independent level; no bus coherency is given.
*/
`default_nettype none
module spi_sync2 #(
  parameter int unsigned W = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta <= '0;
      o_q <= '0;
    end else if (i_ce) begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule
`default_nettype wire

//--- spi_tick_gen.sv
/*
  Master serial clock tick generator: one pulse per half period of the
  serial clock for the selected master mode.
  Assumes i_sub is already synchronised and i_match is a same-clock pulse.
*/
`default_nettype none
module spi_tick_gen (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_run,
  input wire universal_serial_module_spi_pkg::mode_t i_mode,
  input wire logic i_sub,
  input wire logic i_match,
  output logic o_tick
);
  import universal_serial_module_spi_pkg::*;

  logic [HALF_W-1:0] cnt;
  logic [HALF_W-1:0] half;
  logic sub_d;
  logic wrap;

  always_comb begin
    case (i_mode)
      MD_DIV16: half = DIV16_HALF;
      MD_DIV64: half = DIV64_HALF;
      default: half = DIV4_HALF;
    endcase
  end

  assign wrap = (cnt == half - 6'h01);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= '0;
    end else if (i_ce) begin
      if (!i_run || wrap) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sub_d <= 1'b0;
    end else if (i_ce) begin
      sub_d <= i_sub;
    end
  end

  always_comb begin
    case (i_mode)
      MD_DIV4, MD_DIV16, MD_DIV64: o_tick = i_run && wrap;
      MD_SUB: o_tick = i_run && (i_sub != sub_d);
      MD_TIMER: o_tick = i_run && i_match;
      default: o_tick = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

//--- universal_serial_module_spi.sv
/*
  SPI master/slave function of the serial module with its APB registers.
  Assumes APB on the system clock; pins are split into in/out/enable.
*/
// The APB register port and the placing of the registers are this design's own decisions.
// Summary of operation
// - Full-duplex byte transfers, as master or slave per mode field.
// - The master starts transfers and alone drives the serial clock.
// - Select pin driven in master modes when select enable is 1, floating when 0.
// - Software writes outgoing byte to data register; received byte read there.
// - One physical data register shared with the I2C function.
// - Format and data registers accessible only while an SPI mode is chosen.
// - Modes 000, 001, 010: master at system clock over 4, 16, 64.
// - Mode 011: master from subsidiary clock; 100: half timer match rate.
// - Mode field chooses SPI or I2C only while UART select is clear.
// - UART select 1 means UART operation; 0 allows SPI or I2C.
// - Debounce bits act only in I2C; SPI ignores them.
// - Shift order LSB first or MSB first by configuration bit.
// - Capture edge selectable as rising or falling.
// - Clock polarity 0 idles clock high, 1 idles it low.
// - Edge select with polarity picks rising or falling capture edge.
// - Slave select released mid-byte sets incomplete and complete flags.
// - Module enable switches the function; disabled pins lose SPI role.
`default_nettype none
module universal_serial_module_spi (
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [universal_serial_module_spi_pkg::ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_SDI,
  output logic O_SDO,
  output logic O_SDO_OE,
  input wire logic I_SCK_I,
  output logic O_SCK_O,
  output logic O_SCK_OE,
  input wire logic I_SCS_N_I,
  output logic O_SCS_N_O,
  output logic O_SCS_N_OE,
  input wire logic I_SUBCLK,
  input wire logic I_TMR_MATCH
);
  import universal_serial_module_spi_pkg::*;

  mode_ctl_t mode_reg;
  fmt_ctl_t fmt_reg;
  logic [7:0] shift_data;
  state_t state;
  logic [3:0] sync_q;
  logic sdi_s, sck_s, scs_n_s, sub_s;
  logic sck_d, scs_n_d;
  logic tick;
  logic sck_q, sdo_q, scs_q;
  logic [3:0] cap_cnt;
  logic [4:0] edge_cnt;
  logic spi_on, run, master, slave, busy;
  logic scs_active, slave_live;
  logic acc, wr, mapped;
  logic wr_mode, wr_fmt, wr_data;
  logic collide, start;
  logic edge_ev, leading, capture;
  logic done, abort;
  logic [7:0] rd_byte;

  spi_sync2 #(
    .W(4)
  ) u_sync (
    .i_clk(I_MCLK),
    .i_rst_b(I_RST_B),
    .i_ce(I_CE),
    .i_d({I_SDI, I_SCK_I, I_SCS_N_I, I_SUBCLK}),
    .o_q(sync_q)
  );

  assign sdi_s = sync_q[3];
  assign sck_s = sync_q[2];
  assign scs_n_s = sync_q[1];
  assign sub_s = sync_q[0];

  // Mode decode: UART select overrides the mode field
  assign spi_on = is_spi(mode_reg);
  assign run = spi_on && mode_reg.module_enable_bit;
  assign master = run && (mode_reg.mode_field <= MD_TIMER);
  assign slave = run && (mode_reg.mode_field == MD_SLAVE);
  assign busy = (state != ST_IDLE);

  // APB decode; format and data registers hidden outside SPI modes
  assign acc = I_PSEL && I_PENABLE && I_CE;
  assign wr = acc && I_PWRITE;
  assign mapped = (I_PADDR == OFS_MODE) || (I_PADDR == OFS_FMT) ||
                  (I_PADDR == OFS_DATA);
  assign wr_mode = wr && (I_PADDR == OFS_MODE);
  assign wr_fmt = wr && (I_PADDR == OFS_FMT) && spi_on;
  assign wr_data = wr && (I_PADDR == OFS_DATA) && spi_on;
  assign collide = wr_data && busy;
  assign start = wr_data && !busy && master;

  assign O_PREADY = I_CE;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;

  always_comb begin
    rd_byte = 8'h00;
    if (I_PADDR == OFS_MODE) begin
      rd_byte = mode_reg;
    end else if (I_PADDR == OFS_FMT && spi_on) begin
      rd_byte = fmt_reg;
    end else if (I_PADDR == OFS_DATA && spi_on) begin
      rd_byte = shift_data;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PRDATA <= 32'h00000000;
    end else if (I_CE && I_PSEL && !I_PENABLE) begin
      O_PRDATA <= {24'h000000, rd_byte};
    end
  end

  // Slave side edge and select detection on synchronised pins
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sck_d <= 1'b0;
      scs_n_d <= 1'b1;
    end else if (I_CE) begin
      sck_d <= sck_s;
      scs_n_d <= scs_n_s;
    end
  end

  assign scs_active = !fmt_reg.select_pin_enable || !scs_n_s;
  assign slave_live = slave && scs_active;

  spi_tick_gen u_tick (
    .i_clk(I_MCLK),
    .i_rst_b(I_RST_B),
    .i_ce(I_CE),
    .i_run(state == ST_MASTER),
    .i_mode(mode_reg.mode_field),
    .i_sub(sub_s),
    .i_match(I_TMR_MATCH),
    .o_tick(tick)
  );

  // Edge classification: the capture edge is the leading one when
  // the edge select bit is set, whatever the idle level
  always_comb begin
    edge_ev = 1'b0;
    leading = 1'b0;
    if (state == ST_MASTER) begin
      edge_ev = tick;
      leading = (sck_q == !fmt_reg.clock_polarity_bit);
    end else if (slave_live) begin
      edge_ev = (sck_s != sck_d);
      leading = (sck_d == !fmt_reg.clock_polarity_bit);
    end
  end
  assign capture = edge_ev &&
                   (leading == fmt_reg.capture_edge_bit);

  assign done = (state == ST_MASTER) ? (edge_ev &&
                  edge_cnt == EDGE_COUNT - 5'h01) :
                (state == ST_SLAVE || slave_live) && capture &&
                  (cap_cnt == BIT_COUNT - 4'h1);
  assign abort = (state == ST_SLAVE) && fmt_reg.select_pin_enable &&
                 scs_n_s && !scs_n_d && (cap_cnt != 4'h0) &&
                 !done;

  // Transfer sequencer
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state <= ST_IDLE;
    end else if (I_CE) begin
      if (!run) begin
        state <= ST_IDLE;
      end else begin
        case (state)
          ST_IDLE: begin
            if (start) begin
              state <= ST_MASTER;
            end else if (slave_live && !done &&
                         (fmt_reg.select_pin_enable || edge_ev)) begin
              state <= ST_SLAVE;
            end
          end
          ST_MASTER: begin
            if (done || !master) begin
              state <= ST_IDLE;
            end
          end
          ST_SLAVE: begin
            if (done || abort || !slave_live) begin
              state <= ST_IDLE;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Bit and edge counters
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cap_cnt <= 4'h0;
      edge_cnt <= 5'h00;
    end else if (I_CE) begin
      if (!run || done || abort || start ||
          (state == ST_SLAVE && !slave_live)) begin
        cap_cnt <= 4'h0;
        edge_cnt <= 5'h00;
      end else begin
        if (capture) begin
          cap_cnt <= cap_cnt + 4'h1;
        end
        if (edge_ev) begin
          edge_cnt <= edge_cnt + 5'h01;
        end
      end
    end
  end

  // Shared data register doubles as the shifter
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      shift_data <= DATA_RST;
    end else if (I_CE) begin
      if (wr_data && !busy) begin
        shift_data <= I_PWDATA[7:0];
      end else if (capture) begin
        if (fmt_reg.bit_order_bit) begin
          shift_data <= {shift_data[6:0], sdi_s};
        end else begin
          shift_data <= {sdi_s, shift_data[7:1]};
        end
      end
    end
  end

  // Serial data out: first bit on load, next bit on each launch edge
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sdo_q <= 1'b0;
    end else if (I_CE) begin
      if (wr_data && !busy) begin
        sdo_q <= first_bit(I_PWDATA[7:0], fmt_reg.bit_order_bit);
      end else if (edge_ev && !capture) begin
        sdo_q <= first_bit(shift_data, fmt_reg.bit_order_bit);
      end
    end
  end

  // Serial clock: rests at the idle level outside a master transfer
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sck_q <= 1'b1;
    end else if (I_CE) begin
      if (state == ST_MASTER && tick) begin
        sck_q <= !sck_q;
      end else if (state != ST_MASTER) begin
        sck_q <= !fmt_reg.clock_polarity_bit;
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      scs_q <= 1'b1;
    end else if (I_CE) begin
      scs_q <= !(state == ST_MASTER || start);
    end
  end

  // Pin drive
  assign O_SCK_O = sck_q;
  assign O_SCK_OE = master;
  assign O_SDO = sdo_q;
  assign O_SDO_OE = master || slave_live;
  assign O_SCS_N_O = scs_q;
  assign O_SCS_N_OE = master && fmt_reg.select_pin_enable;

  // Mode control register; debounce bits are stored only
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      mode_reg <= MODE_RST;
    end else if (I_CE) begin
      if (wr_mode) begin
        mode_reg <= I_PWDATA[7:0];
      end
      if (abort) begin
        mode_reg.incomplete_flag <= 1'b1;
      end
    end
  end

  // Format control register; hardware flag sets win over writes
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      fmt_reg <= FMT_RST;
    end else if (I_CE) begin
      if (wr_fmt) begin
        fmt_reg <= I_PWDATA[7:0];
      end
      if (done || abort) begin
        fmt_reg.transfer_complete_flag <= 1'b1;
      end
      if (collide) begin
        fmt_reg.write_collision_flag <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_B);

  sequence s_master_done;
    I_CE && state == ST_MASTER && done;
  endsequence

  sequence s_slave_abort;
    I_CE && abort;
  endsequence

  a_slave_clock_in: assert property (slave |-> !O_SCK_OE)
    else $error("serial clock driven in slave mode");
  a_select_float: assert property (
    !fmt_reg.select_pin_enable |-> !O_SCS_N_OE)
    else $error("select pin driven while disabled");
  a_disable_pins: assert property (
    I_CE && !mode_reg.module_enable_bit |-> !O_SCK_OE && !O_SDO_OE &&
    !O_SCS_N_OE ##1 state == ST_IDLE)
    else $error("pins driven while module disabled");
  a_done_flag: assert property (
    s_master_done |=> fmt_reg.transfer_complete_flag &&
    state == ST_IDLE)
    else $error("completion not flagged");
  a_collide_drop: assert property (
    I_CE && collide |=> fmt_reg.write_collision_flag &&
    ($stable(shift_data) || $past(capture)))
    else $error("collision write not dropped");
  a_abort_flags: assert property (
    s_slave_abort |=> mode_reg.incomplete_flag &&
    fmt_reg.transfer_complete_flag && state == ST_IDLE)
    else $error("incomplete transfer not flagged");
  a_idle_level: assert property (
    I_CE && state == ST_IDLE ##1 I_CE && state == ST_IDLE &&
    $stable(fmt_reg.clock_polarity_bit) |->
    O_SCK_O == !fmt_reg.clock_polarity_bit)
    else $error("serial clock not at idle level");
  a_hidden_regs: assert property (
    I_CE && wr && !spi_on |=> $stable(fmt_reg) ||
    $past(done || collide || abort))
    else $error("hidden register written");
  a_uart_override: assert property (
    mode_reg.uart_select_bit |-> !master && !slave)
    else $error("SPI active in UART mode");
  a_edge_count: assert property (
    I_CE && start |=> state == ST_MASTER && edge_cnt == 5'h00 &&
    cap_cnt == 4'h0)
    else $error("transfer start not clean");
endmodule
`default_nettype wire

//--- spi_peer.sv
/*
  Far-side model of the serial link: a slave that answers the design's
  master, or a master that clocks the design as slave.
  Assumes the bench resolves the shared lines and loads each byte.
*/
`default_nettype none
module spi_peer (
  input wire logic i_clk,
  input wire logic i_sck,
  input wire logic i_din,
  input wire logic i_cap_rise,
  input wire logic i_msb,
  output logic o_dout,
  output logic o_sck,
  output logic o_sck_oe,
  output logic o_scs_n,
  output logic [7:0] o_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  int caps;
  initial begin
    o_dout = 1'b0;
    o_sck = 1'b1;
    o_sck_oe = 1'b0;
    o_scs_n = 1'b1;
    o_rx = 8'h00;
  end
  task automatic load(input logic [7:0] d, input logic m, input logic master,
                      input logic idle);
    sh = d;
    caps = 0;
    o_sck_oe = master;
    o_sck = idle;
    o_dout = m ? d[7] : d[0];
  endtask
  // Slave role moves on right after capture, master role on the far edge
  always @(i_sck) begin
    if (!(o_sck_oe && o_scs_n)) begin
      if (i_sck === i_cap_rise) begin
        o_rx <= i_msb ? {o_rx[6:0], i_din} : {i_din, o_rx[7:1]};
        caps++;
      end
      if (((i_sck === i_cap_rise) ^ o_sck_oe) && caps > 0) begin
        sh = i_msb ? sh << 1 : sh >> 1;
        o_dout <= i_msb ? sh[7] : sh[0];
      end
    end
  end
  task automatic send(input int n, input int half);
    @(posedge i_clk);
    o_scs_n <= 1'b0;
    repeat (half) @(posedge i_clk);
    repeat (2 * n) begin
      o_sck <= ~o_sck;
      repeat (half) @(posedge i_clk);
    end
    o_scs_n <= 1'b1;
    o_dout <= ~o_dout;
    repeat (half) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

//--- universal_serial_module_spi_bench.sv
/*
  Self-checking bench of the SPI function: APB master tasks, random bytes
  and formats, master and slave transfers against the peer model.
  Assumes the design package and the peer model are compiled first.
*/
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module universal_serial_module_spi_bench;
  import universal_serial_module_spi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_b = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h1E;
  logic pready, pslverr, sdo, sdo_oe, sck_o, sck_oe, scs_o, scs_oe, prev_sck;
  logic subclk = 0, tmr = 0, cap_rise = 1, msb = 0;
  logic p_dout, p_sck, p_sck_oe, p_scs;
  logic [7:0] p_rx, cfg, tx, ptx;
  wire logic sck_line = sck_oe ? sck_o : (p_sck_oe ? p_sck : 1'b1);
  wire logic scs_line = scs_oe ? scs_o : p_scs;
  wire logic sdo_line = sdo_oe ? sdo : 1'b1;
  int failures = 0, checks = 0, cyc = 0, toggles = 0, t_first, t_last;

  always #5 mclk = ~mclk;

  universal_serial_module_spi universal_serial_module_spi_i (.I_MCLK(mclk), .I_RST_B(rst_b), .I_CE(ce),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_SDI(p_dout), .O_SDO(sdo), .O_SDO_OE(sdo_oe),
    .I_SCK_I(sck_line), .O_SCK_O(sck_o), .O_SCK_OE(sck_oe),
    .I_SCS_N_I(scs_line), .O_SCS_N_O(scs_o), .O_SCS_N_OE(scs_oe),
    .I_SUBCLK(subclk), .I_TMR_MATCH(tmr));
  spi_peer spi_peer_i (.i_clk(mclk), .i_sck(sck_line), .i_din(sdo_line),
    .i_cap_rise(cap_rise), .i_msb(msb), .o_dout(p_dout), .o_sck(p_sck),
    .o_sck_oe(p_sck_oe), .o_scs_n(p_scs), .o_rx(p_rx));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic conclude();
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Clock sources, edge counting and the hang limit
  always @(posedge mclk) begin
    cyc++;
    subclk <= (cyc % 7 == 0) ? ~subclk : subclk;
    tmr <= (cyc % 5 == 0);
    if (sck_oe === 1'b1 && sck_o !== prev_sck) begin
      if (toggles == 0) t_first = cyc;
      t_last = cyc;
      toggles++;
    end
    prev_sck <= sck_o;
    if (cyc == 40000) begin
      failures++;
      conclude();
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input string nm, input logic [11:0] a,
                        input logic [7:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    `CHK(nm, {24'h000000, x}, r)
  endtask
  task automatic wait_trf();
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_FMT, 8'h00, r, e);
      n++;
    end while (r[0] !== 1'b1 && n < 400);
  endtask
  task automatic new_cfg(input logic cs);
    seed = xorshift(seed);
    cfg = {2'b00, seed[3:1], cs, 2'b00};
    tx = seed[15:8];
    ptx = seed[23:16];
    cap_rise = ~(cfg[5] ^ cfg[4]);
    msb = cfg[3];
  endtask

  task automatic master_xfer(input logic [2:0] md);
    logic [7:0] mreg;
    int half;
    new_cfg(seed[0]);
    mreg = {md, 1'b0, seed[25:24], 1'b1, 1'b0};
    half = (4 << (2 * md)) / 2;
    wr(OFS_MODE, mreg);
    rd_chk("mode", OFS_MODE, mreg);
    wr(OFS_FMT, cfg);
    repeat (3) @(posedge mclk);
    `CHK("sck idle", ~cfg[5], sck_o)
    spi_peer_i.load(ptx, cfg[3], 1'b0, 1'b1);
    toggles = 0;
    wr(OFS_DATA, tx);
    wr(OFS_DATA, ~tx);
    `CHK("select oe", cfg[2], scs_oe)
    `CHK("select low", 1'b0, scs_o)
    wait_trf();
    rd_chk("flags", OFS_FMT, cfg | 8'h03);
    rd_chk("rx data", OFS_DATA, ptx);
    `CHK("peer rx", tx, p_rx)
    `CHK("edges", 16, toggles)
    if (md < 3) `CHK("span", 15 * half, t_last - t_first)
    wr(OFS_FMT, cfg);
  endtask

  initial begin
    logic [31:0] r;
    logic e;
    logic [7:0] off [4] = '{8'h00, 8'h12, 8'hC2, 8'hE2};
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    rd_chk("mode reset", OFS_MODE, 8'hE0);
    rd_chk("fmt hidden", OFS_FMT, 8'h00);
    apb(1'b0, 12'h00C, 8'h00, r, e);
    `CHK("unmapped", 1'b1, e)
    wr(OFS_MODE, 8'h02);
    rd_chk("fmt reset", OFS_FMT, 8'h00);
    rd_chk("data reset", OFS_DATA, 8'h00);
    for (int i = 0; i < 10; i++) master_xfer(3'(i % 5));
    foreach (off[j]) begin
      wr(OFS_MODE, off[j]);
      wr(OFS_DATA, 8'h5A);
      wait_trf();
      `CHK("sck oe off", 1'b0, sck_oe)
      `CHK("sdo oe off", 1'b0, sdo_oe)
      rd_chk("fmt off", OFS_FMT, j ? 8'h00 : cfg);
    end
    wr(OFS_MODE, 8'hA2);
    new_cfg(1'b1);
    wr(OFS_FMT, cfg);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_DATA, tx);
      spi_peer_i.load(ptx, cfg[3], 1'b1, ~cfg[5]);
      spi_peer_i.send(k ? 3 : 8, 10);
      wait_trf();
      `CHK("slave sck oe", 1'b0, sck_oe)
      rd_chk("slave flags", OFS_FMT, cfg | 8'h01);
      if (k == 0) begin
        rd_chk("slave rx", OFS_DATA, ptx);
        `CHK("slave tx", tx, p_rx)
      end else rd_chk("incomplete", OFS_MODE, 8'hA3);
      wr(OFS_FMT, cfg);
    end
    conclude();
  end
endmodule
`default_nettype wire
